// ### design/pseq_pkg.sv
`default_nettype none
package pseq_pkg;

    localparam int PSEQ_PC_W = 14;
    localparam int PSEQ_WORD_W = 16;
    localparam int PSEQ_PHASES = 4;
    localparam logic [1:0] PSEQ_LAST_PHASE = 2'h3;
    localparam logic [7:0] PSEQ_PCL_OFFSET = 8'h06;
    localparam int PSEQ_BANK_BIT = 5;
    localparam logic [13:0] PSEQ_RESET_VECTOR = 14'h0000;
    localparam int PSEQ_NUM_INT = 6;
    // Index 0 has the highest priority
    localparam logic [13:0] PSEQ_INT_VECTOR [PSEQ_NUM_INT] = '{
        14'h0004, 14'h0008, 14'h000c, 14'h0010, 14'h0014, 14'h0018
    };
    localparam int PSEQ_INT_EXT = 0;
    localparam int PSEQ_INT_FIRST_TIMER_COUNTER = 1;
    localparam int PSEQ_INT_SECOND_TIMER_COUNTER = 2;
    localparam int PSEQ_INT_UART = 3;
    localparam int PSEQ_INT_I2C = 4;
    localparam int PSEQ_INT_MULTI = 5;
    localparam int PSEQ_START_PERIODS = 1024;
    localparam logic [10:0] PSEQ_START_CYCLES = 11'(PSEQ_START_PERIODS);

    typedef enum logic [2:0] {
        PSEQ_ST_START = 3'b001,
        PSEQ_ST_RUN = 3'b010,
        PSEQ_ST_HALT = 3'b100
    } pseq_state_type;

    typedef struct packed {
        logic jump;
        logic ret;
        logic skip;
        logic [12:0] target;
        logic [13:0] stack_word;
    } pseq_ctl_type;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pseq_dbus_type;

endpackage
`default_nettype wire

// ### design/pseq_startup.sv
`timescale 1ns/100ps
`default_nettype none
module pseq_startup (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic restart_i,
    output logic done_o
);
    logic [10:0] count_ff;
    logic [10:0] nxt_count;

    always_comb begin
        nxt_count = count_ff;
        if (restart_i) begin
            nxt_count = '0;
        end else if (count_ff != pseq_pkg::PSEQ_START_CYCLES) begin
            nxt_count = count_ff + 11'h001;
        end
    end

    // Counts from reset release as well as from each restart
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    assign done_o = (count_ff == pseq_pkg::PSEQ_START_CYCLES) && !restart_i;

    start_len_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        restart_i |=> !done_o [*8])
        else $error("start-up period ended too early");

endmodule // pseq_startup
`default_nettype wire

// ### design/program_sequencer.sv
// Notes on behaviour
// - Four system clocks form one instruction cycle, one phase each.
// - Next word is fetched while the previous one executes.
// - Any program counter change costs a dummy refill cycle.
// - Program counter is 14 bits, addressing 16384 words of 16 bits.
// - After each fetch the program counter advances by one.
// - Taken skip discards the fetched next instruction as a dummy cycle.
// - Taken skip leaves old value plus two, within the current bank.
// - Low byte at data address 06H; writing it jumps within 256 words.
// - Jump or call takes 13 operand bits, bit 13 from bank select bit.
// - Two 8192-word banks; bank pointer bit 5 picks the bank.
// - Returns restore all 14 bits from the stack, ignoring the bank.
// - Chip reset loads program counter with zero.
// - Enabled external interrupt with stack room vectors to 004H.
// - Enabled first timer overflow with stack room vectors to 008H.
// - Power-up or wake-up waits 1024 clocks before executing.
// - Enabled second timer overflow with stack room vectors to 00CH.
// - Enabled serial port interrupt with stack room vectors to 010H.
// - Enabled I2C slave interrupt with stack room vectors to 014H.
// - Enabled multi-function interrupt with stack room vectors to 018H.
`timescale 1ns/100ps
`default_nettype none
module program_sequencer (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [15:0] prog_data_i,
    output logic [13:0] prog_addr_o,
    output logic prog_rd_o,
    input wire pseq_pkg::pseq_ctl_type ctl_i,
    input wire logic [7:0] bank_pointer_i,
    input wire pseq_pkg::pseq_dbus_type dbus_i,
    output logic [7:0] data_rdata_o,
    input wire logic [5:0] int_pending_i,
    input wire logic [5:0] int_enable_i,
    input wire logic stack_full_i,
    input wire logic halt_i,
    input wire logic wake_i,
    output logic [15:0] instr_o,
    output logic instr_valid_o,
    output logic cycle_end_o,
    output logic int_ack_o,
    output logic [13:0] push_addr_o,
    output logic running_o
);
    pseq_pkg::pseq_state_type state_ff;
    pseq_pkg::pseq_state_type nxt_state;
    logic [1:0] phase_ff;
    logic [13:0] pc_ff;
    logic [13:0] nxt_pc;
    logic [15:0] instr_ff;
    logic exec_valid_ff;
    logic [7:0] rdata_ff;
    logic int_ack_ff;
    logic [13:0] push_addr_ff;
    logic cycle_end;
    logic start_done;
    logic pcl_wr;
    logic transfer;
    logic int_take;
    logic [13:0] int_vector;
    logic [5:0] int_live;

    pseq_startup u_startup (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .restart_i(state_ff == pseq_pkg::PSEQ_ST_HALT && wake_i),
        .done_o(start_done)
    );

    assign cycle_end = (state_ff == pseq_pkg::PSEQ_ST_RUN)
        && (phase_ff == pseq_pkg::PSEQ_LAST_PHASE);
    assign pcl_wr = dbus_i.wr && (dbus_i.addr == pseq_pkg::PSEQ_PCL_OFFSET);
    assign transfer = exec_valid_ff
        && (ctl_i.jump || ctl_i.ret || ctl_i.skip || pcl_wr);

    // Service is held off while the stack is full
    assign int_live = stack_full_i ? 6'h00 : (int_pending_i & int_enable_i);

    always_comb begin
        int_vector = pseq_pkg::PSEQ_INT_VECTOR[0];
        for (int i = pseq_pkg::PSEQ_NUM_INT - 1; i >= 0; i--) begin
            if (int_live[i]) begin
                int_vector = pseq_pkg::PSEQ_INT_VECTOR[i];
            end
        end
    end

    // Taken only on a boundary not already redirecting the counter
    assign int_take = cycle_end && exec_valid_ff && !transfer
        && (int_live != 6'h00);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            pseq_pkg::PSEQ_ST_START: begin
                if (start_done) begin
                    nxt_state = pseq_pkg::PSEQ_ST_RUN;
                end
            end
            pseq_pkg::PSEQ_ST_RUN: begin
                if (cycle_end && halt_i) begin
                    nxt_state = pseq_pkg::PSEQ_ST_HALT;
                end
            end
            pseq_pkg::PSEQ_ST_HALT: begin
                if (wake_i) begin
                    nxt_state = pseq_pkg::PSEQ_ST_START;
                end
            end
            default: begin
                nxt_state = pseq_pkg::PSEQ_ST_START;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= pseq_pkg::PSEQ_ST_START;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_ff <= 2'h0;
        end else if (state_ff == pseq_pkg::PSEQ_ST_RUN) begin
            phase_ff <= phase_ff + 2'h1;
        end else begin
            phase_ff <= 2'h0;
        end
    end

    always_comb begin
        nxt_pc = pc_ff + 14'h0001;
        if (exec_valid_ff) begin
            if (ctl_i.ret) begin
                nxt_pc = ctl_i.stack_word;
            end else if (ctl_i.jump) begin
                nxt_pc = {bank_pointer_i[pseq_pkg::PSEQ_BANK_BIT], ctl_i.target};
            end else if (pcl_wr) begin
                nxt_pc = {pc_ff[13:8], dbus_i.wdata};
            end else if (ctl_i.skip) begin
                nxt_pc = {pc_ff[13], pc_ff[12:0] + 13'h0001};
            end else if (int_live != 6'h00) begin
                nxt_pc = {1'b0, int_vector[12:0]};
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pc_ff <= pseq_pkg::PSEQ_RESET_VECTOR;
        end else if (cycle_end) begin
            pc_ff <= nxt_pc;
        end
    end

    // Fetch of the current word overlaps execution of the previous one
    // Held across halt so the word fetched last runs first after wake-up
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            instr_ff <= '0;
            exec_valid_ff <= 1'b0;
        end else if (cycle_end) begin
            instr_ff <= prog_data_i;
            exec_valid_ff <= !(transfer || int_take);
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            int_ack_ff <= 1'b0;
            push_addr_ff <= '0;
        end else begin
            int_ack_ff <= int_take;
            if (int_take) begin
                push_addr_ff <= pc_ff;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_ff <= '0;
        end else if (dbus_i.addr == pseq_pkg::PSEQ_PCL_OFFSET) begin
            rdata_ff <= pc_ff[7:0];
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign prog_addr_o = pc_ff;
    assign prog_rd_o = cycle_end;
    assign instr_o = instr_ff;
    assign instr_valid_o = exec_valid_ff;
    assign cycle_end_o = cycle_end;
    assign int_ack_o = int_ack_ff;
    assign push_addr_o = push_addr_ff;
    assign data_rdata_o = rdata_ff;
    assign running_o = (state_ff == pseq_pkg::PSEQ_ST_RUN);

    phase_wrap_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        cycle_end |-> ##4 (cycle_end || state_ff != pseq_pkg::PSEQ_ST_RUN))
        else $error("instruction cycle is not four clocks");

    fetch_pipe_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        cycle_end |=> instr_o == $past(prog_data_i))
        else $error("fetched word not passed to execute");

    step_one_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (cycle_end && !exec_valid_ff) |=> pc_ff == $past(pc_ff) + 14'h0001)
        else $error("program counter did not advance by one");

    skip_two_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (cycle_end && exec_valid_ff && ctl_i.skip && !ctl_i.jump && !ctl_i.ret && !pcl_wr)
        |=> pc_ff[13] == $past(pc_ff[13]) && pc_ff[12:0] == $past(pc_ff[12:0]) + 13'h0001)
        else $error("skip target wrong");

    jump_bank_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (cycle_end && exec_valid_ff && ctl_i.jump && !ctl_i.ret)
        |=> pc_ff == {$past(bank_pointer_i[5]), $past(ctl_i.target)})
        else $error("jump target wrong");

    ret_full_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (cycle_end && exec_valid_ff && ctl_i.ret) |=> pc_ff == $past(ctl_i.stack_word))
        else $error("return address wrong");

    pcl_short_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (cycle_end && exec_valid_ff && pcl_wr && !ctl_i.jump && !ctl_i.ret)
        |=> pc_ff == {$past(pc_ff[13:8]), $past(dbus_i.wdata)})
        else $error("low byte write jump wrong");

    dummy_slot_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (cycle_end && (transfer || int_take)) |=> !instr_valid_o [*4])
        else $error("no dummy cycle after transfer");

    vector_bank0_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        int_take |=> int_ack_o && pc_ff[13] == 1'b0 && pc_ff[1:0] == 2'h0
        && push_addr_o == $past(pc_ff))
        else $error("interrupt vector wrong");

    ext_vector_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        (int_take && int_live[0]) |=> pc_ff == 14'h0004)
        else $error("external interrupt vector wrong");

endmodule // program_sequencer
`default_nettype wire

// ### verification/pseq_prog_mem.sv
`timescale 1ns/100ps
`default_nettype none
module pseq_prog_mem (
    input wire logic [13:0] addr_i,
    input wire logic rd_i,
    output logic [15:0] data_o
);
    // Each word names its own address; outside the read strobe the bus shows junk
    assign data_o = rd_i ? {2'h2, addr_i} : ~{2'h2, addr_i};
endmodule // pseq_prog_mem
`default_nettype wire

// ### verification/program_sequencer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module program_sequencer_bench;
    logic mclk, rst_n, rd, vld, cend, ack, run, stack_full, halt, wake, a;
    logic [15:0] pdata, instr, w;
    logic [13:0] paddr, push_addr, f, f0;
    logic [7:0] bp, rdata;
    logic [5:0] pend, ena;
    pseq_pkg::pseq_ctl_type ctl, c;
    pseq_pkg::pseq_dbus_type dbus, d;
    int bad_count = 0;
    int num_checks = 0;
    int ticks = 0;
    int n;

    program_sequencer dut_u (.mclk_i(mclk), .reset_n_i(rst_n), .prog_data_i(pdata),
        .prog_addr_o(paddr), .prog_rd_o(rd), .ctl_i(ctl), .bank_pointer_i(bp), .dbus_i(dbus),
        .data_rdata_o(rdata), .int_pending_i(pend), .int_enable_i(ena),
        .stack_full_i(stack_full), .halt_i(halt), .wake_i(wake), .instr_o(instr),
        .instr_valid_o(vld), .cycle_end_o(cend), .int_ack_o(ack), .push_addr_o(push_addr),
        .running_o(run));
    pseq_prog_mem mem_u (.addr_i(paddr), .rd_i(rd), .data_o(pdata));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        ticks <= ticks + 1;
        if (ticks == 12000) begin
            bad_count = bad_count + 1;
            give_verdict();
        end
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    function automatic logic [15:0] word_at(logic [13:0] adr);
        return {2'h2, adr};
    endfunction

    task to_end(output int k);
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (cend !== 1'b1 && k < 8);
    endtask

    task wait_run(output int k);
        k = 0;
        while (run !== 1'b1 && k < 1100) begin
            @(posedge mclk);
            k++;
        end
    endtask

    // Holds the request until a valid cycle end takes it
    task exec(input pseq_pkg::pseq_ctl_type cc, input pseq_pkg::pseq_dbus_type dd);
        int k;
        int j;
        j = 0;
        @(posedge mclk);
        ctl <= cc;
        dbus <= dd;
        do begin
            to_end(k);
            j++;
        end while (vld !== 1'b1 && j < 4);
        f = paddr;
        w = instr;
        ctl <= '0;
        dbus <= '0;
        #1;
    endtask

    task t_seq;
        exec('0, '0);
        for (int i = 0; i < 3; i++) begin
            f0 = f;
            exec('0, '0);
            chk(f, f0 + 14'h1, "increment");
            chk(w, word_at(f0), "pipelined word");
        end
        to_end(n);
        to_end(n);
        chk(16'(n), 16'h4, "cycle length");
    endtask

    task t_jump_skip(input logic [7:0] b, input logic [13:0] exp);
        @(posedge mclk);
        bp <= b;
        c = '0;
        c.jump = 1'b1;
        c.target = 13'h1ffe;
        exec(c, '0);
        chk(paddr, exp, "jump target");
        chk(vld, 1'b0, "jump refill");
        c = '0;
        c.skip = 1'b1;
        exec(c, '0);
        chk(w, word_at(exp), "target word");
        chk(paddr, {exp[13], exp[12:0] + 13'h0002}, "skip wrap");
        chk(vld, 1'b0, "skip discard");
    endtask

    task rd_chk(input logic [7:0] adr, input logic [7:0] exp);
        @(posedge mclk);
        dbus <= '{1'b0, adr, 8'h00};
        @(posedge mclk);
        #1;
        chk(rdata, exp, "low byte read");
    endtask

    task t_low_byte;
        exec('0, '{1'b1, 8'h06, 8'h5a});
        chk(paddr, {f[13:8], 8'h5a}, "short jump");
        chk(vld, 1'b0, "short jump refill");
        rd_chk(8'h06, 8'h5a);
        rd_chk(8'h07, 8'h00);
        c = '0;
        c.ret = 1'b1;
        c.stack_word = 14'h3123;
        exec(c, '0);
        chk(paddr, 14'h3123, "return");
    endtask

    task t_int(input logic [5:0] p, input logic [5:0] e, input logic full,
        input logic [13:0] v);
        @(posedge mclk);
        pend <= p;
        ena <= e;
        stack_full <= full;
        exec('0, '0);
        a = ack;
        chk(paddr, v == 0 ? f + 14'h1 : v, "vector");
        @(posedge mclk);
        pend <= '0;
        #1;
        a = a | ack;
        chk(a, v != 0, "acknowledge");
        if (v != 0)
            chk(push_addr, f, "pushed address");
    endtask

    initial begin
        {rst_n, stack_full, halt, wake, pend, ena, ctl, dbus} = '0;
        bp = 8'h00;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        wait_run(n);
        chk(16'(n >= 1023 && n <= 1027), 16'h1, "start-up wait");
        #1;
        chk(paddr, 14'h0, "reset vector");
        t_seq();
        t_jump_skip(8'h1f, 14'h1ffe);
        t_jump_skip(8'h20, 14'h3ffe);
        t_low_byte();
        for (int i = 0; i < 6; i++)
            t_int(6'h1 << i, 6'h3f, 1'b0, 14'(4 * (i + 1)));
        t_int(6'h3c, 6'h3f, 1'b0, 14'h000c);
        t_int(6'h01, 6'h3f, 1'b1, 14'h0);
        t_int(6'h01, 6'h3e, 1'b0, 14'h0);
        @(posedge mclk);
        halt <= 1'b1;
        wait (run === 1'b0);
        @(posedge mclk);
        f0 = paddr;
        halt <= 1'b0;
        wake <= 1'b1;
        @(posedge mclk);
        wake <= 1'b0;
        wait_run(n);
        chk(16'(n >= 1022 && n <= 1027), 16'h1, "wake-up wait");
        exec('0, '0);
        chk(f, f0, "no fetch lost over halt");
        chk(w, word_at(f0 - 14'h0001), "held word after wake");
        give_verdict();
    end
endmodule // program_sequencer_bench
`default_nettype wire
